/* core/expiry_counter.sv */
// Saturating expiry counter with a clear input.
// Assumes single clock, synchronous active-high reset.

`timescale 1ns/1ps
`default_nettype none

module expiry_counter
  import pd_watchdog_pkg::*;
#(
  parameter int WIDTH = EXPIRY_CNT_WIDTH
) (
  input  wire logic             i_clk,    // System clock
  input  wire logic             i_reset,  // Synchronous reset, active high
  input  wire logic             i_count,  // One-cycle expiry event
  input  wire logic             i_clear,  // One-cycle clear request
  output logic [WIDTH-1:0]      o_value   // Current count
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("expiry_counter: WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] value_q;
  logic             at_max;

  assign at_max  = &value_q;
  assign o_value = value_q;

  // A clear in the same cycle as an expiry keeps that expiry, so no event is lost.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      value_q <= WIDTH'(EXPIRY_CNT_RESET);
    end else if (i_clear) begin
      value_q <= i_count ? WIDTH'(1) : '0;
    end else if (i_count && !at_max) begin
      value_q <= value_q + WIDTH'(1);
    end
  end

endmodule

`default_nettype wire

/* core/pd_watchdog_pkg.sv */
// Constants shared by the process data watchdog status block and its counters.
// Assumes byte-wide register accesses addressed by a 16-bit byte address.

package pd_watchdog_pkg;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [15:0] ADDR_WD_STATE_LO    = 16'h0440;
  localparam logic [15:0] ADDR_WD_STATE_HI    = 16'h0441;
  localparam logic [15:0] ADDR_PD_EXPIRY_CNT  = 16'h0442;
  localparam logic [15:0] ADDR_HOST_EXPIRY_CNT = 16'h0443;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam int          WD_STATE_BIT       = 0;
  localparam int          EVENT_REQ_BIT      = 6;
  localparam int          TIME_WIDTH         = 16;
  localparam int          EXPIRY_CNT_WIDTH   = 8;
  localparam logic [15:0] WD_TIME_DISABLED   = 16'h0000;
  localparam logic [7:0]  EXPIRY_CNT_RESET   = 8'h00;
  localparam logic [7:0]  RDATA_RESET        = 8'h00;
  localparam logic        WD_STATE_RESET     = 1'b1;
  localparam logic        EVENT_REQ_RESET    = 1'b0;

  // ---------------------------------------------------------------------------
  // Watchdog states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_OFF     = 2'b00,
    WD_RUN     = 2'b01,
    WD_EXPIRED = 2'b10
  } wd_state_e;

endpackage

/* core/pd_watchdog_status.sv */
// Process data watchdog with its status flag, expiry counters and event request.
// Assumes the watchdog divider supplies one tick pulse per basic increment, and
// that both register sides present byte accesses as one-cycle strobes.

`timescale 1ns/1ps
`default_nettype none

module pd_watchdog_status
  import pd_watchdog_pkg::*;
#(
  parameter int TIME_W = TIME_WIDTH,
  parameter int CNT_W  = EXPIRY_CNT_WIDTH
) (
  input  wire logic              i_clk,             // System clock, 50 MHz
  input  wire logic              i_reset,           // Synchronous reset, active high
  // Watchdog timing
  input  wire logic              i_wd_tick,         // One basic watchdog increment
  input  wire logic [TIME_W-1:0] i_wd_time,         // Process data watchdog time
  input  wire logic              i_bcm_trigger,     // Write to a triggering channel manager
  input  wire logic              i_host_wd_expired, // Host interface watchdog expiry pulse
  input  wire logic              i_ack_by_write,    // Host acknowledge by write selected
  // Network master side register access
  input  wire logic [15:0]       i_nm_addr,         // Master byte address
  input  wire logic              i_nm_wr,           // Master write strobe
  input  wire logic              i_nm_rd,           // Master read strobe
  input  wire logic [7:0]        i_nm_wdata,        // Master write data, ignored
  output logic [7:0]             o_nm_rdata,        // Master read data
  // Local host side register access
  input  wire logic [15:0]       i_lh_addr,         // Host byte address
  input  wire logic              i_lh_wr,           // Host write strobe
  input  wire logic              i_lh_rd,           // Host read strobe
  input  wire logic [7:0]        i_lh_wdata,        // Host write data, ignored
  output logic [7:0]             o_lh_rdata,        // Host read data
  // Status toward the rest of the controller
  output logic                   o_wd_state,        // 1 running or off, 0 expired
  output logic                   o_wd_expired,      // One-cycle expiry pulse
  output logic                   o_event_req        // Application layer event request bit
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  generate
    if (TIME_W < 1 || TIME_W > 32) begin : g_bad_time
      $error("pd_watchdog_status: TIME_W must be 1 to 32");
    end
    if (CNT_W < 1 || CNT_W > 8) begin : g_bad_cnt
      $error("pd_watchdog_status: CNT_W must fit one byte");
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  wd_state_e          state_q;
  wd_state_e          state_d;
  logic [TIME_W-1:0]  ticks_q;
  logic [TIME_W-1:0]  ticks_d;
  logic               expire;
  logic               expired_pulse_q;
  logic               event_req_q;
  logic [7:0]         nm_rdata_q;
  logic [7:0]         lh_rdata_q;
  logic [CNT_W-1:0]   pd_count;
  logic [CNT_W-1:0]   host_count;
  logic               wd_disabled;
  logic               lh_status_hit;
  logic               nm_count_hit;
  logic               lh_ack;
  logic               counters_clear;
  logic [7:0]         status_lo;

  // The write data on both sides is deliberately unused: a write to these
  // registers is at most an action, never a store.
  logic               unused_wdata;
  assign unused_wdata = ^{i_nm_wdata, i_lh_wdata};

  // ---------------------------------------------------------------------------
  // Watchdog timer
  // ---------------------------------------------------------------------------
  assign wd_disabled = (i_wd_time == TIME_W'(WD_TIME_DISABLED));

  always_comb begin
    state_d = state_q;
    ticks_d = ticks_q;
    expire  = 1'b0;
    case (state_q)
      WD_OFF: begin
        ticks_d = '0;
        if (!wd_disabled) begin
          state_d = WD_RUN;
        end
      end
      WD_RUN: begin
        if (wd_disabled) begin
          state_d = WD_OFF;
          ticks_d = '0;
        end else if (i_bcm_trigger) begin
          ticks_d = '0;
        end else if (i_wd_tick) begin
          if (ticks_q + TIME_W'(1) >= i_wd_time) begin
            state_d = WD_EXPIRED;
            ticks_d = '0;
            expire  = 1'b1;
          end else begin
            ticks_d = ticks_q + TIME_W'(1);
          end
        end
      end
      WD_EXPIRED: begin
        ticks_d = '0;
        if (wd_disabled) begin
          state_d = WD_OFF;
        end else if (i_bcm_trigger) begin
          state_d = WD_RUN;
        end
      end
      default: begin
        state_d = WD_OFF;
        ticks_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= WD_OFF;
      ticks_q <= '0;
    end else begin
      state_q <= state_d;
      ticks_q <= ticks_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      expired_pulse_q <= 1'b0;
    end else begin
      expired_pulse_q <= expire;
    end
  end

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Master accesses to the status register are reads only; nothing decodes a
  // master write there, so such writes fall away.
  assign lh_status_hit  = (i_lh_addr == ADDR_WD_STATE_LO) || (i_lh_addr == ADDR_WD_STATE_HI);
  assign nm_count_hit   = (i_nm_addr == ADDR_PD_EXPIRY_CNT) || (i_nm_addr == ADDR_HOST_EXPIRY_CNT);
  assign counters_clear = i_nm_wr && nm_count_hit;

  // Only one of the two acknowledge forms is live at a time.
  assign lh_ack = lh_status_hit && (i_ack_by_write ? i_lh_wr
                                                   : i_lh_rd);

  // ---------------------------------------------------------------------------
  // Event request
  // ---------------------------------------------------------------------------
  // An expiry in the same cycle as an acknowledge wins, so the host still sees it.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      event_req_q <= EVENT_REQ_RESET;
    end else if (expire) begin
      event_req_q <= 1'b1;
    end else if (lh_ack) begin
      event_req_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Expiry counters
  // ---------------------------------------------------------------------------
  expiry_counter #(
    .WIDTH (CNT_W)
  ) u_pd_count (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_count (expire),
    .i_clear (counters_clear),
    .o_value (pd_count)
  );

  expiry_counter #(
    .WIDTH (CNT_W)
  ) u_host_count (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_count (i_host_wd_expired),
    .i_clear (counters_clear),
    .o_value (host_count)
  );

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_comb begin
    status_lo               = 8'h00;
    status_lo[WD_STATE_BIT] = (state_q != WD_EXPIRED);
  end

  // Host writes never reach the counters: the host path only reads them.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      lh_rdata_q <= RDATA_RESET;
    end else if (i_lh_rd) begin
      case (i_lh_addr)
        ADDR_WD_STATE_LO:    lh_rdata_q <= status_lo;
        ADDR_PD_EXPIRY_CNT:  lh_rdata_q <= 8'(pd_count);
        ADDR_HOST_EXPIRY_CNT: lh_rdata_q <= 8'(host_count);
        default:             lh_rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      nm_rdata_q <= RDATA_RESET;
    end else if (i_nm_rd) begin
      case (i_nm_addr)
        ADDR_WD_STATE_LO:    nm_rdata_q <= status_lo;
        ADDR_PD_EXPIRY_CNT:  nm_rdata_q <= 8'(pd_count);
        ADDR_HOST_EXPIRY_CNT: nm_rdata_q <= 8'(host_count);
        default:             nm_rdata_q <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_nm_rdata   = nm_rdata_q;
  assign o_lh_rdata   = lh_rdata_q;
  assign o_wd_state   = (state_q != WD_EXPIRED);
  assign o_wd_expired = expired_pulse_q;
  assign o_event_req  = event_req_q;

endmodule

`default_nettype wire

/* test/pd_watchdog_status_monitor.sv */
// Checker for the process data watchdog status block.
// Sees only the top module's ports and is attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module pd_watchdog_status_monitor
  import pd_watchdog_pkg::*;
#(
  parameter int TIME_W = TIME_WIDTH
) (
  input wire logic              i_clk,
  input wire logic              i_reset,
  input wire logic              i_wd_tick,
  input wire logic [TIME_W-1:0] i_wd_time,
  input wire logic              i_bcm_trigger,
  input wire logic              i_host_wd_expired,
  input wire logic              i_ack_by_write,
  input wire logic [15:0]       i_nm_addr,
  input wire logic              i_nm_wr,
  input wire logic              i_nm_rd,
  input wire logic [7:0]        i_nm_wdata,
  input wire logic [7:0]        o_nm_rdata,
  input wire logic [15:0]       i_lh_addr,
  input wire logic              i_lh_wr,
  input wire logic              i_lh_rd,
  input wire logic [7:0]        i_lh_wdata,
  input wire logic [7:0]        o_lh_rdata,
  input wire logic              o_wd_state,
  input wire logic              o_wd_expired,
  input wire logic              o_event_req
);
  // A host access to either status byte that acknowledges in the selected mode.
  wire logic lh_st = (i_lh_addr == ADDR_WD_STATE_LO) || (i_lh_addr == ADDR_WD_STATE_HI);
  wire logic ack   = lh_st && (i_ack_by_write ? i_lh_wr : i_lh_rd);
  // A master clear with no host expiry beside it, and a later master read of the host counter.
  wire logic clr_wr  = i_nm_wr && (i_nm_addr == ADDR_PD_EXPIRY_CNT) && !i_host_wd_expired;
  wire logic host_rd = i_nm_rd && (i_nm_addr == ADDR_HOST_EXPIRY_CNT);

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_flag_expired: assert property (o_wd_expired |-> !o_wd_state && o_event_req)
    else $error("expiry pulse without cleared flag and event");
  chk_pulse_single: assert property (o_wd_expired |=> !o_wd_expired)
    else $error("expiry pulse longer than one cycle");
  // A tick edge may expire the watchdog, and expiry wins over acknowledge.
  chk_ack_clears: assert property (ack && !i_wd_tick |=> !o_event_req)
    else $error("acknowledge did not clear event request");
  chk_event_holds: assert property (o_event_req && !ack |=> o_event_req)
    else $error("event request dropped without acknowledge");
  chk_nm_status: assert property (i_nm_rd && i_nm_addr == ADDR_WD_STATE_LO
    |=> o_nm_rdata == {7'h00, $past(o_wd_state)})
    else $error("master status read data wrong");
  chk_lh_status: assert property (i_lh_rd && i_lh_addr == ADDR_WD_STATE_LO
    |=> o_lh_rdata == {7'h00, $past(o_wd_state)})
    else $error("host status read data wrong");
  // A host expiry between the clear and the read would count again, so those cycles must be quiet.
  chk_count_clear: assert property (((clr_wr ##1 host_rd) or (clr_wr ##1 !i_host_wd_expired ##1 host_rd)
    or (clr_wr ##1 !i_host_wd_expired [*2] ##1 host_rd)) |=> o_nm_rdata == 8'h00)
    else $error("counter write did not clear both counters");
  chk_off_flag: assert property (i_wd_time == WD_TIME_DISABLED |=> o_wd_state)
    else $error("disabled watchdog shows expired");
  chk_restart_flag: assert property (i_bcm_trigger && i_wd_time != WD_TIME_DISABLED |=> o_wd_state)
    else $error("restart did not restore the flag");

  cov_expiry: cover property (o_wd_expired);
  cov_ack_read: cover property (ack && !i_ack_by_write);
  cov_clear: cover property (i_nm_wr && i_nm_addr == ADDR_PD_EXPIRY_CNT);
endmodule

bind pd_watchdog_status pd_watchdog_status_monitor #(.TIME_W(TIME_W)) u_pd_watchdog_status_monitor (.*);
`default_nettype wire

/* test/pd_watchdog_status_tb.sv */
// Self-checking bench for the process data watchdog status block.
// Drives both register sides by byte strobes and a divider model for ticks.
`timescale 1ns/1ps
`default_nettype none
module pd_watchdog_status_tb;
  import pd_watchdog_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_wd_tick;
  logic        tick_en = 1'b0;
  logic [15:0] i_wd_time = 16'h0000;
  logic        i_bcm_trigger = 1'b0, i_host_wd_expired = 1'b0, i_ack_by_write = 1'b0;
  logic [15:0] i_nm_addr = 16'h0000, i_lh_addr = 16'h0000;
  logic        i_nm_wr = 1'b0, i_nm_rd = 1'b0, i_lh_wr = 1'b0, i_lh_rd = 1'b0;
  logic [7:0]  i_nm_wdata = 8'h00, i_lh_wdata = 8'h00; // Writers supply zero.
  logic [7:0]  o_nm_rdata, o_lh_rdata;
  logic        o_wd_state, o_wd_expired, o_event_req;
  int          mismatches = 0, tests_run = 0, cycles = 0;

  pd_watchdog_status u_pd_watchdog_status (.*);
  wd_tick_source u_wd_tick_source (.i_clk(i_clk), .i_reset(i_reset), .i_enable(tick_en), .o_tick(i_wd_tick));

  always #10 i_clk = ~i_clk;

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up;
    $display("TB: %0d mismatches, %0d tests_run", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic acc(input logic nm, input logic wr, input logic [15:0] a);
    @(posedge i_clk);
    if (nm) begin
      i_nm_addr <= a;
      {i_nm_wr, i_nm_rd} <= {wr, !wr};
    end else begin
      i_lh_addr <= a;
      {i_lh_wr, i_lh_rd} <= {wr, !wr};
    end
    @(posedge i_clk);
    {i_nm_wr, i_nm_rd, i_lh_wr, i_lh_rd} <= 4'h0;
    #1;
  endtask
  task automatic nm_rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b1, 1'b0, a);
    cmp8(o_nm_rdata, e);
  endtask
  task automatic lh_rd(input logic [15:0] a, input logic [7:0] e);
    acc(1'b0, 1'b0, a);
    cmp8(o_lh_rdata, e);
  endtask
  task automatic trig;
    @(posedge i_clk);
    i_bcm_trigger <= 1'b1;
    @(posedge i_clk);
    i_bcm_trigger <= 1'b0;
    #1;
    cmp1(o_wd_state, 1'b1);
  endtask
  task automatic wait_exp;
    int n;
    n = 0;
    while (o_wd_expired !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    cmp1(o_wd_expired, 1'b1);
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    nm_rd(ADDR_WD_STATE_LO, 8'h01);
    lh_rd(ADDR_PD_EXPIRY_CNT, 8'h00);
    nm_rd(16'h0450, 8'h00);
    @(posedge i_clk);
    i_wd_time <= 16'h0003;
    tick_en   <= 1'b1;
    wait_exp();
    cmp1(o_wd_state, 1'b0);
    cmp1(o_event_req, 1'b1);
    nm_rd(ADDR_WD_STATE_LO, 8'h00);
    nm_rd(ADDR_PD_EXPIRY_CNT, 8'h01);
    acc(1'b1, 1'b1, ADDR_WD_STATE_LO);
    acc(1'b0, 1'b1, ADDR_WD_STATE_HI);
    cmp1(o_event_req, 1'b1);
    lh_rd(ADDR_WD_STATE_HI, 8'h00);
    cmp1(o_event_req, 1'b0);
    trig();
    wait_exp();
    @(posedge i_clk);
    i_ack_by_write <= 1'b1;
    lh_rd(ADDR_WD_STATE_LO, 8'h00);
    cmp1(o_event_req, 1'b1);
    acc(1'b0, 1'b1, ADDR_WD_STATE_LO);
    cmp1(o_event_req, 1'b0);
    acc(1'b0, 1'b1, ADDR_PD_EXPIRY_CNT);
    lh_rd(ADDR_PD_EXPIRY_CNT, 8'h02);
    repeat (260) begin
      trig();
      wait_exp();
    end
    nm_rd(ADDR_PD_EXPIRY_CNT, 8'hFF);
    repeat (2) begin
      @(posedge i_clk);
      i_host_wd_expired <= 1'b1;
      @(posedge i_clk);
      i_host_wd_expired <= 1'b0;
    end
    lh_rd(ADDR_HOST_EXPIRY_CNT, 8'h02);
    acc(1'b1, 1'b1, ADDR_PD_EXPIRY_CNT);
    nm_rd(ADDR_HOST_EXPIRY_CNT, 8'h00);
    nm_rd(ADDR_PD_EXPIRY_CNT, 8'h00);
    @(posedge i_clk);
    i_wd_time <= WD_TIME_DISABLED;
    @(posedge i_clk);
    #1;
    cmp1(o_wd_state, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire

/* test/wd_tick_source.sv */
// Model of the watchdog divider that feeds basic increments to the block.
// Assumes one clock; ticks are one-cycle pulses every PERIOD cycles.
`timescale 1ns/1ps
`default_nettype none
module wd_tick_source #(
  parameter int PERIOD = 4
) (
  input  wire logic i_clk,     // System clock
  input  wire logic i_reset,   // Synchronous reset, active high
  input  wire logic i_enable,  // Divider running
  output logic      o_tick     // One basic increment
);
  int cnt_q;
  // A short period keeps expiry runs brief; the block only sees pulses.
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_enable) begin
      cnt_q  <= 0;
      o_tick <= 1'b0;
    end else begin
      cnt_q  <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      o_tick <= (cnt_q == PERIOD - 1);
    end
  end
endmodule
`default_nettype wire
